// file: pkg/mbss_pkg.sv
// Purpose: shared constants and carriers of the serial sharer bridge
// Assumes: 40 MHz ref_clk, byte streams from external line codecs
// Notes: register offsets are byte addresses on the AHB-Lite port
package mbss_pkg;
   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_HZ = 40_000_000;
   localparam int MS_PER_S = 1000;
   localparam int MS_CYC = CLK_HZ / MS_PER_S;   // cycles per millisecond
   localparam logic [15:0] TMO_DEF = 16'h03E8; // slave timeout, 1000 ms
   localparam logic [15:0] TMO_MIN = 16'h0064; // least timeout, 100 ms
   localparam logic [15:0] CACHE_MIN = 16'h000A; // 10 ms
   localparam logic [15:0] CACHE_MAX = 16'hFFFA; // 65530 ms
   localparam int RAW_BUF = 512;                  // full-duplex burst limit
   // ****************************************************************
   // register map and fields
   // ****************************************************************
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_TMO = 8'h04;
   localparam logic [7:0] A_CACHE = 8'h08;
   localparam logic [7:0] A_IDRNG = 8'h0C;
   localparam logic [7:0] A_OFFS = 8'h10;
   localparam logic [7:0] A_STAT = 8'h14;
   localparam int CTRL_MB_B = 0;     // modbus converter mode
   localparam int CTRL_SLV_LSB = 1;  // 2-bit slave port index
   localparam int CTRL_ASC_LSB = 3;  // 3 bits, ascii framing per port
   localparam int CTRL_FDX_B = 6;    // raw ports are full-duplex capable
   localparam int RNG_HI_LSB = 8;
   localparam int STAT_DROP_LSB = 16;
   localparam logic [6:0] CTRL_DEF = 7'h04; // raw mode, slaves on port 2
   localparam logic [7:0] ID_LO_DEF = 8'h01;
   localparam logic [7:0] ID_HI_DEF = 8'hF7;
   // ****************************************************************
   // modbus characters and codes
   // ****************************************************************
   localparam logic [7:0] CH_COLON = 8'h3A;
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_LF = 8'h0A;
   localparam logic [7:0] FC_RD_HOLD = 8'h03;
   localparam logic [7:0] FC_RD_INP = 8'h04;
   localparam int KEY_LEN = 6;        // id, function, address, quantity
   localparam int NPORT = 3;
   typedef struct packed
   {
      logic vld;        // character present
      logic [7:0] data; // character
      logic eof;        // last character of a frame (rtu)
   } mbss_char_s;
endpackage

// file: logic/mbss_char_tx.sv
// Purpose: frames binary bytes as rtu bytes or ascii hex characters
// Assumes: one byte accepted per frame step, last flags frame end
// Notes: checksums are added by the external line codec
`timescale 1ns/1ps
`default_nettype none
module mbss_char_tx
   import mbss_pkg::*;
(
   input wire logic ref_clk,       // clock
   input wire logic resetn,        // sync reset, low
   input wire logic ascii,         // ascii framing when high
   input wire logic in_vld,        // byte offered
   input wire logic [7:0] in_data, // byte
   input wire logic in_last,       // last byte of frame
   output logic in_rdy,            // byte taken
   output mbss_char_s tx,          // character out
   input wire logic tx_rdy         // sink takes character
);
   typedef enum {T_IDLE, T_COLON, T_HI, T_LO, T_CR, T_LF} mbss_tx_e;
   mbss_tx_e st_r;
   logic [7:0] byte_r;
   logic last_r;
   logic first_r;
   logic go;

   // hex digit of a nibble
   function automatic logic [7:0] hexc(input logic [3:0] n);
      hexc = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
   endfunction

   assign in_rdy = (st_r == T_IDLE);
   assign go = tx.vld && tx_rdy;

   // character sequencer
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         st_r <= T_IDLE;
         byte_r <= 8'h00;
         last_r <= 1'b0;
         first_r <= 1'b1;
      end
      else
      begin
         case (st_r)
            T_IDLE:
               if (in_vld)
               begin
                  byte_r <= in_data;
                  last_r <= in_last;
                  first_r <= in_last;
                  st_r <= !ascii ? T_LO : (first_r ? T_COLON : T_HI);
               end
            T_COLON: if (go) st_r <= T_HI;
            T_HI: if (go) st_r <= T_LO;
            T_LO: if (go) st_r <= (ascii && last_r) ? T_CR : T_IDLE;
            T_CR: if (go) st_r <= T_LF;
            T_LF: if (go) st_r <= T_IDLE;
            default: st_r <= T_IDLE;
         endcase
      end
   end

   // character for the present step
   always_comb
   begin
      tx.vld = (st_r != T_IDLE);
      tx.eof = 1'b0;
      tx.data = byte_r;
      case (st_r)
         T_COLON: tx.data = CH_COLON;
         T_HI: tx.data = hexc(byte_r[7:4]);
         T_LO:
         begin
            tx.data = ascii ? hexc(byte_r[3:0]) : byte_r;
            tx.eof = !ascii && last_r;
         end
         T_CR: tx.data = CH_CR;
         T_LF:
         begin
            tx.data = CH_LF;
            tx.eof = 1'b1;
         end
         default: tx.data = byte_r;
      endcase
   end
endmodule
`default_nettype wire

// file: logic/mbss_bridge.sv
// Purpose: serial sharer bridge, raw converter or modbus sharer
// Assumes: external uarts give byte streams at each port's own rate
// Notes: registers over AHB-Lite, zero wait states, always OKAY
// What this block does
// - raw mode passes bytes between two ports of different settings
// - raw full duplex only on capable ports, within 512-byte bursts
// - modbus mode lets two masters share the slaves on one port
// - each port has its own rtu or ascii framing, translated between
// - requests go only to the port set as the slave port
// - after the request, wait the timeout; no reply drops it
// - read replies may be served from cache, 10-65530 ms, 0 off
// - requests with unit id outside the virtual range are ignored
// - physical id is virtual id plus a signed offset
`timescale 1ns/1ps
`default_nettype none
module mbss_bridge
   import mbss_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYC, // cycles per millisecond
   parameter int DEPTH = 256         // frame buffer bytes
)
(
   input wire logic ref_clk,                  // 40 MHz clock
   input wire logic resetn,                   // sync reset, low
   input wire logic hsel,                     // ahb select
   input wire logic [31:0] haddr,             // ahb address
   input wire logic [1:0] htrans,             // ahb transfer type
   input wire logic hwrite,                   // ahb write
   input wire logic [2:0] hsize,              // ahb size, word only
   input wire logic [31:0] hwdata,            // ahb write data
   input wire logic hready,                   // ahb bus ready
   output logic hreadyout,                    // ahb slave ready
   output logic [31:0] hrdata,                // ahb read data
   output logic hresp,                        // ahb response
   input wire mbss_char_s [NPORT-1:0] rx_i,   // characters from ports
   output logic [NPORT-1:0] rx_rdy,           // characters taken
   output mbss_char_s [NPORT-1:0] tx_o,       // characters to ports
   input wire logic [NPORT-1:0] tx_rdy        // ports take characters
);
   typedef enum {S_IDLE, S_RXQ, S_CHK, S_TXQ, S_WAIT, S_TXR} mbss_st_e;
   localparam int CW = $clog2(DEPTH + 1);
   mbss_st_e state_r;
   logic [6:0] ctrl_r;
   logic [15:0] tmo_r, cache_r, tmo_cnt_r;
   logic [7:0] id_lo_r, id_hi_r, drop_r, vid_r;
   logic [8:0] offs_r;
   logic [31:0] hrdata_r;
   logic wr_pend_r;
   logic [7:0] wa_r;
   logic [7:0] req_mem [DEPTH];
   logic [7:0] rsp_mem [DEPTH];
   logic [7:0] key_r [KEY_LEN];
   logic [CW-1:0] q_cnt_r, r_cnt_r, rd_r;
   logic [1:0] g_r, last_r, src, slv, pa, pb, pick;
   logic pick_vld, mb_en, fdx, hi_vld_r, got_r, match_r, key_vld_r, dir_r;
   logic [3:0] hi_r;
   logic [15:0] wait_ms_r, age_r;
   logic [$clog2(MS_CYCLES)-1:0] cyc_r;
   logic ms_tick, byte_we, f_end, take, in_rng, hit, full, ab_ok, ba_ok;
   logic [7:0] byte_d, c_d, phys;
   logic [4:0] hx;
   logic [9:0] burst_r;
   logic [15:0] wv;
   logic q_rdy, r_rdy, q_vld, r_vld;
   mbss_char_s q_tx, r_tx;

   // ****************************************************************
   // ahb-lite register slave
   // ****************************************************************
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;
   assign wv = hwdata[15:0];
   assign mb_en = ctrl_r[CTRL_MB_B];
   assign slv = ctrl_r[CTRL_SLV_LSB +: 2];
   assign fdx = ctrl_r[CTRL_FDX_B];

   // address phase captured; read data ready for the data phase
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         wr_pend_r <= 1'b0;
         wa_r <= 8'h00;
         hrdata_r <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_r <= hsel && hready && htrans[1] && hwrite;
         wa_r <= haddr[7:0];
         if (hsel && hready && htrans[1] && !hwrite)
         begin
            case (haddr[7:0])
               A_CTRL: hrdata_r <= {25'h0, ctrl_r};
               A_TMO: hrdata_r <= {16'h0, tmo_r};
               A_CACHE: hrdata_r <= {16'h0, cache_r};
               A_IDRNG: hrdata_r <= {16'h0, id_hi_r, id_lo_r};
               A_OFFS: hrdata_r <= {{23{offs_r[8]}}, offs_r};
               A_STAT: hrdata_r <= {8'h0, drop_r, tmo_cnt_r};
               default: hrdata_r <= 32'h0000_0000; // unmapped reads zero
            endcase
         end
      end
   end

   // configuration writes, clamped to legal ranges; a ctrl write naming slave port 3 is dropped whole
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         ctrl_r <= CTRL_DEF;
         tmo_r <= TMO_DEF;
         cache_r <= 16'h0000;
         id_lo_r <= ID_LO_DEF;
         id_hi_r <= ID_HI_DEF;
         offs_r <= 9'h000;
      end
      else if (wr_pend_r)
      begin
         case (wa_r)
            A_CTRL: if (hwdata[CTRL_SLV_LSB +: 2] != 2'h3) ctrl_r <= hwdata[6:0];
            A_TMO: tmo_r <= (wv < TMO_MIN) ? TMO_MIN : wv;
            A_CACHE: cache_r <= (wv == 16'h0) ? 16'h0 : (wv < CACHE_MIN) ?
               CACHE_MIN : (wv > CACHE_MAX) ? CACHE_MAX : wv;
            A_IDRNG: {id_hi_r, id_lo_r} <= hwdata[15:0];
            A_OFFS: offs_r <= (hwdata[8:0] == 9'h100) ? 9'h101 : hwdata[8:0];
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // millisecond time base
   // ****************************************************************
   assign ms_tick = (cyc_r == ($clog2(MS_CYCLES))'(MS_CYCLES - 1));
   always_ff @(posedge ref_clk)
   begin
      if (!resetn) cyc_r <= '0;
      else cyc_r <= ms_tick ? '0 : cyc_r + 1'b1;
   end

   // ****************************************************************
   // modbus sharer
   // ****************************************************************
   // the two master ports and round-robin pick between them
   assign pa = (slv == 2'd0) ? 2'd1 : 2'd0;
   assign pb = (slv == 2'd2) ? 2'd1 : 2'd2;
   assign pick = (rx_i[pa].vld && (!rx_i[pb].vld || last_r != pa)) ? pa : pb;
   assign pick_vld = rx_i[pa].vld || rx_i[pb].vld;
   assign src = (state_r == S_WAIT) ? slv : g_r;
   assign take = (state_r == S_RXQ || state_r == S_WAIT) && rx_i[src].vld;
   assign c_d = rx_i[src].data;
   assign hx = (c_d >= 8'h30 && c_d <= 8'h39) ? {1'b1, c_d[3:0]} :
      (c_d >= 8'h41 && c_d <= 8'h46) ? {1'b1, c_d[3:0] + 4'h9} : 5'h00;

   // frame decoder for the selected port's framing
   always_comb
   begin
      byte_we = 1'b0;
      f_end = 1'b0;
      byte_d = c_d;
      if (take && !ctrl_r[CTRL_ASC_LSB + src])
      begin
         byte_we = 1'b1;
         f_end = rx_i[src].eof;
      end
      else if (take)
      begin
         f_end = (c_d == CH_LF);
         byte_we = hx[4] && hi_vld_r;
         byte_d = {hi_r, hx[3:0]};
      end
   end

   // ascii nibble pairing
   always_ff @(posedge ref_clk)
   begin
      // pairing survives idle gaps between characters
      if (!resetn || (take && c_d == CH_COLON))
         hi_vld_r <= 1'b0;
      else if (take && hx[4])
         hi_vld_r <= !hi_vld_r;
      if (!resetn) hi_r <= 4'h0;
      else if (take && hx[4]) hi_r <= hx[3:0];
   end

   assign in_rng = (q_cnt_r != '0) && req_mem[0] >= id_lo_r &&
      req_mem[0] <= id_hi_r;
   assign phys = req_mem[0] + offs_r[7:0]; // two's complement wrap
   assign hit = cache_r != 16'h0 && key_vld_r && age_r < cache_r &&
      match_r && q_cnt_r == CW'(KEY_LEN);

   // request sequencer
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         state_r <= S_IDLE;
         g_r <= 2'd0;
         last_r <= 2'd0;
         drop_r <= 8'h00;
         tmo_cnt_r <= 16'h0000;
      end
      else
      begin
         case (state_r)
            S_IDLE:
               if (mb_en && pick_vld)
               begin
                  g_r <= pick;
                  last_r <= pick;
                  state_r <= S_RXQ;
               end
            S_RXQ: if (f_end) state_r <= S_CHK;
            S_CHK:
               if (!in_rng)
               begin
                  state_r <= S_IDLE;
                  drop_r <= drop_r + 8'h01;
               end
               else state_r <= hit ? S_TXR : S_TXQ;
            S_TXQ: if (q_tx.eof && tx_rdy[slv]) state_r <= S_WAIT;
            S_WAIT:
               if (f_end) state_r <= S_TXR;
               else if (!got_r && wait_ms_r >= tmo_r)
               begin
                  state_r <= S_IDLE;
                  tmo_cnt_r <= tmo_cnt_r + 16'h0001;
               end
            S_TXR: if (r_tx.eof && tx_rdy[g_r]) state_r <= S_IDLE;
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // buffers, counts and cache key
   always_ff @(posedge ref_clk)
   begin
      if (state_r == S_RXQ && byte_we && q_cnt_r < CW'(DEPTH))
         req_mem[q_cnt_r[CW-2:0]] <= byte_d;
      if (state_r == S_CHK && in_rng) req_mem[0] <= phys;
      if (state_r == S_WAIT && byte_we && r_cnt_r < CW'(DEPTH))
         rsp_mem[r_cnt_r[CW-2:0]] <= byte_d;
      if (state_r == S_WAIT && f_end && (req_mem[1] == FC_RD_HOLD ||
         req_mem[1] == FC_RD_INP))
      begin
         key_r[0] <= vid_r;
         for (int i = 1; i < KEY_LEN; i++) key_r[i] <= req_mem[i];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!resetn || state_r == S_IDLE)
      begin
         q_cnt_r <= '0;
         match_r <= 1'b1;
      end
      else if (state_r == S_RXQ && byte_we && q_cnt_r < CW'(DEPTH))
      begin
         q_cnt_r <= q_cnt_r + 1'b1;
         if (q_cnt_r < CW'(KEY_LEN) && byte_d != key_r[q_cnt_r[2:0]])
            match_r <= 1'b0;
      end
      if (!resetn) vid_r <= 8'h00;
      else if (state_r == S_CHK) vid_r <= req_mem[0];
      if (!resetn || state_r == S_TXQ) r_cnt_r <= '0;
      else if (state_r == S_WAIT && byte_we && r_cnt_r < CW'(DEPTH))
         r_cnt_r <= r_cnt_r + 1'b1;
      if (!resetn || state_r != S_WAIT) {got_r, wait_ms_r} <= '0;
      else
      begin
         got_r <= got_r || take;
         if (ms_tick) wait_ms_r <= wait_ms_r + 16'h0001;
      end
   end

   // cache validity and age; a new reply of another kind retires it
   always_ff @(posedge ref_clk)
   begin
      if (!resetn || !mb_en) key_vld_r <= 1'b0;
      else if (state_r == S_WAIT && f_end)
         key_vld_r <= req_mem[1] == FC_RD_HOLD || req_mem[1] == FC_RD_INP;
      if (!resetn || (state_r == S_WAIT && f_end)) age_r <= 16'h0000;
      else if (ms_tick && age_r != 16'hFFFF) age_r <= age_r + 16'h0001;
   end

   // transmit pointer shared by request and reply
   always_ff @(posedge ref_clk)
   begin
      if (!resetn || state_r == S_CHK || state_r == S_WAIT) rd_r <= '0;
      else if ((q_vld && q_rdy) || (r_vld && r_rdy)) rd_r <= rd_r + 1'b1;
   end

   assign q_vld = state_r == S_TXQ && rd_r < q_cnt_r;
   assign r_vld = state_r == S_TXR && rd_r < r_cnt_r;

   mbss_char_tx u_req_tx (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .ascii(ctrl_r[CTRL_ASC_LSB + slv]),
      .in_vld(q_vld),
      .in_data(req_mem[rd_r[CW-2:0]]),
      .in_last(rd_r == q_cnt_r - 1'b1),
      .in_rdy(q_rdy),
      .tx(q_tx),
      .tx_rdy(tx_rdy[slv])
   );

   // reply id turned back into the master's virtual id
   mbss_char_tx u_rsp_tx (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .ascii(ctrl_r[CTRL_ASC_LSB + g_r]),
      .in_vld(r_vld),
      .in_data(rd_r == '0 ? vid_r : rsp_mem[rd_r[CW-2:0]]),
      .in_last(rd_r == r_cnt_r - 1'b1),
      .in_rdy(r_rdy),
      .tx(r_tx),
      .tx_rdy(tx_rdy[g_r])
   );

   // ****************************************************************
   // raw converter
   // ****************************************************************
   assign full = fdx && burst_r < 10'(RAW_BUF);
   assign ab_ok = !mb_en && (full || !dir_r);
   assign ba_ok = !mb_en && (full || dir_r);

   // half duplex hands the line over once its owner falls quiet
   always_ff @(posedge ref_clk)
   begin
      if (!resetn) dir_r <= 1'b0;
      else if (!full && !dir_r && !rx_i[pa].vld && rx_i[slv].vld) dir_r <= 1'b1;
      else if (!full && dir_r && !rx_i[slv].vld && rx_i[pa].vld) dir_r <= 1'b0;
      if (!resetn || mb_en || tx_o[slv].eof || tx_o[pa].eof) burst_r <= '0;
      else if (rx_rdy[pa] && rx_i[pa].vld && burst_r != 10'h3FF)
         burst_r <= burst_r + 10'h001;
   end

   // port steering
   always_comb
   begin
      for (int p = 0; p < NPORT; p++)
      begin
         tx_o[p] = '0;
         rx_rdy[p] = 1'b0;
      end
      if (!mb_en)
      begin
         if (ab_ok) tx_o[slv] = rx_i[pa];
         if (ba_ok) tx_o[pa] = rx_i[slv];
         rx_rdy[pa] = ab_ok && tx_rdy[slv];
         rx_rdy[slv] = ba_ok && tx_rdy[pa];
      end
      else
      begin
         if (state_r == S_TXQ) tx_o[slv] = q_tx;
         if (state_r == S_TXR) tx_o[g_r] = r_tx;
         rx_rdy[src] = state_r == S_RXQ || state_r == S_WAIT;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   property p_drop;
      @(posedge ref_clk) disable iff (!resetn)
      state_r == S_CHK && !in_rng |=> state_r == S_IDLE;
   endproperty
   a_drop: assert property (p_drop) else $error("out-of-range id served");

   property p_tmo_floor;
      @(posedge ref_clk) disable iff (!resetn) tmo_r >= TMO_MIN;
   endproperty
   a_tmo_floor: assert property (p_tmo_floor) else $error("timeout too low");

   property p_cache_rng;
      @(posedge ref_clk) disable iff (!resetn)
      cache_r == 16'h0 || (cache_r >= CACHE_MIN && cache_r <= CACHE_MAX);
   endproperty
   a_cache_rng: assert property (p_cache_rng) else $error("bad cache period");

   property p_offset;
      @(posedge ref_clk) disable iff (!resetn)
      state_r == S_CHK && in_rng |=> req_mem[0] == $past(req_mem[0]) + $past(offs_r[7:0]);
   endproperty
   a_offset: assert property (p_offset) else $error("physical id wrong");

   property p_wait_bound;
      @(posedge ref_clk) disable iff (!resetn)
      state_r == S_WAIT && !got_r |-> wait_ms_r <= tmo_r;
   endproperty
   a_wait_bound: assert property (p_wait_bound) else $error("waited past timeout");

   property p_one_rx;
      @(posedge ref_clk) disable iff (!resetn) mb_en |-> $onehot0(rx_rdy);
   endproperty
   a_one_rx: assert property (p_one_rx) else $error("two ports taken at once");

   property p_route;
      @(posedge ref_clk) disable iff (!resetn)
      mb_en && state_r != S_TXR |-> !tx_o[pa].vld && !tx_o[pb].vld;
   endproperty
   a_route: assert property (p_route) else $error("request on master port");

   property p_raw;
      @(posedge ref_clk) disable iff (!resetn)
      !mb_en && tx_o[slv].vld |-> tx_o[slv].data == rx_i[pa].data;
   endproperty
   a_raw: assert property (p_raw) else $error("raw data altered");

   property p_half;
      @(posedge ref_clk) disable iff (!resetn)
      !mb_en && !fdx |-> !(rx_rdy[pa] && rx_rdy[slv]);
   endproperty
   a_half: assert property (p_half) else $error("full duplex not allowed");

   property p_hit;
      @(posedge ref_clk) disable iff (!resetn)
      state_r == S_CHK && in_rng && hit |=> state_r == S_TXR ##1 state_r == S_TXR;
   endproperty
   a_hit: assert property (p_hit) else $error("cache hit not served");

   c_timeout: cover property (@(posedge ref_clk) disable iff (!resetn)
      state_r == S_WAIT ##1 state_r == S_IDLE);
   c_reply: cover property (@(posedge ref_clk) disable iff (!resetn)
      state_r == S_WAIT ##1 state_r == S_TXR);
   c_cached: cover property (@(posedge ref_clk) disable iff (!resetn)
      state_r == S_CHK && in_rng && hit);
endmodule
`default_nettype wire

// file: verif/mbss_slave_model.sv
// Purpose: serial slave on the slave port, echoes each request frame
// Assumes: rtu bytes, eof on the last byte of a frame
// Notes: mute swallows replies so the bridge has to time out
`timescale 1ns/1ps
`default_nettype none
module mbss_slave_model
   import mbss_pkg::*;
(
   input wire logic ref_clk,     // clock
   input wire logic resetn,      // sync reset, low
   input wire logic mute,        // no reply when high
   input wire mbss_char_s tx,    // request characters
   output logic tx_rdy,          // always taking
   output mbss_char_s rx,        // reply characters
   input wire logic rx_rdy,      // bridge takes reply character
   output logic [7:0] first_id   // id byte of the last frame
);
   logic [7:0] q[$];
   logic [7:0] rq[$];
   logic [7:0] last;
   assign tx_rdy = 1'b1;
   initial rx = '0;
   // ****************************************************************
   // collect frames, echo them, hold each character until taken
   // ****************************************************************
   always @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         q = {};
         rq = {};
         last = 8'h00;
      end
      else
      begin
         if (rx.vld && rx_rdy)
            last = rq.pop_front();
         if (tx.vld)
         begin
            q.push_back(tx.data);
            if (q.size() == 1)
               first_id <= tx.data;
            if (tx.eof && !mute)
               rq = q;
            if (tx.eof)
               q = {};
         end
      end
      // idle line shows the inverse so stale data never looks valid
      if (rq.size() > 0)
         rx <= '{1'b1, rq[0], rq.size() == 1};
      else
         rx <= '{1'b0, ~last, 1'b0};
   end
endmodule
`default_nettype wire

// file: verif/mbss_bridge_tb_top.sv
// Purpose: self-checking bench of the sharer bridge
// Assumes: 1 ms shortened to 40 cycles, rtu framing on all ports
// Notes: port 0 is the master driven here, port 2 the slave model
`timescale 1ns/1ps
`default_nettype none
module mbss_bridge_tb_top;
   import mbss_pkg::*;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic hready;
   logic [31:0] hrdata;
   logic hresp;
   logic mute = 1'b1;
   mbss_char_s m0 = '0;
   mbss_char_s s_rx;
   wire mbss_char_s [NPORT-1:0] rx_w;
   mbss_char_s [NPORT-1:0] tx_w;
   logic [NPORT-1:0] rx_rdy;
   logic s_rdy;
   logic [7:0] sid;
   logic [7:0] mq[$];
   logic [31:0] r;
   int n_mismatch = 0;
   int n_compared = 0;
   logic [8:0] ra [10] = '{9'h004, 9'h008, 9'h00C, 9'h010, 9'h018,
      9'h014, 9'h104, 9'h108, 9'h108, 9'h110};
   logic [31:0] rw [10] = '{0, 0, 0, 0, 0, 0, 32'h32, 32'h5, 32'hFFFF,
      32'hFFFFFFF6};
   logic [31:0] re [10] = '{32'h3E8, 0, 32'hF701, 0, 0, 0, 32'h64,
      32'hA, 32'hFFFA, 32'hFFFFFFF6};
   assign rx_w = {s_rx, 10'h000, m0};
   always #12.5 ref_clk = ~ref_clk;
   mbss_bridge #(.MS_CYCLES(40), .DEPTH(256)) u_mbss_bridge (.ref_clk,
      .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
      .hready, .hreadyout(hready), .hrdata, .hresp, .rx_i(rx_w), .rx_rdy,
      .tx_o(tx_w), .tx_rdy({s_rdy, 2'b11}));
   mbss_slave_model u_mbss_slave_model (.ref_clk, .resetn, .mute,
      .tx(tx_w[2]), .tx_rdy(s_rdy), .rx(s_rx), .rx_rdy(rx_rdy[2]),
      .first_id(sid));
   // replies seen by the master on port 0
   always @(posedge ref_clk)
      if (tx_w[0].vld === 1'b1)
         mq.push_back(tx_w[0].data);
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_compared++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one phase sampled on hready (sel 0) or rx_rdy[0] (sel 1); settled value read mid-cycle
   task automatic hold_for(input int sel);
      logic ok;
      do
      begin
         @(negedge ref_clk);
         ok = (sel == 0) ? hready : rx_rdy[0];
         @(posedge ref_clk);
      end while (ok !== 1'b1);
   endtask
   task automatic ahb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      hold_for(0);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      hold_for(0);
      r = hrdata;
   endtask
   // read request: id, read holding, start 0, quantity 1
   task automatic send_req(input logic [7:0] id);
      logic [7:0] b [6];
      b = '{id, FC_RD_HOLD, 8'h00, 8'h00, 8'h00, 8'h01};
      mq = {};
      for (int i = 0; i < 6; i++)
      begin
         m0 <= '{1'b1, b[i], i == 5};
         hold_for(1);
      end
      m0 <= '{1'b0, 8'hFE, 1'b0};
   endtask
   task automatic final_report;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // watchdog far beyond the three 150 ms waits
   initial
   begin
      repeat (60000) @(posedge ref_clk);
      n_mismatch++;
      final_report();
   end
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial
   begin
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      ahb(1'b0, A_CTRL, 0);
      chk("ctrl", r, 32'h4);
      for (int i = 0; i < 10; i++)
      begin
         if (ra[i][8])
            ahb(1'b1, ra[i][7:0], rw[i]);
         ahb(1'b0, ra[i][7:0], 0);
         chk("reg", r, re[i]);
      end
      send_req(8'h21);
      chk("raw byte", sid, 8'h21);
      ahb(1'b1, A_CTRL, 32'h5);
      mute = 1'b0;
      send_req(8'h14);
      // master waits longer than the 100 ms slave timeout
      for (int i = 0; i < 6000 && mq.size() < 6; i++)
         @(posedge ref_clk);
      // request reaches the slave only after the check cycle
      chk("phys id", sid, 8'h0A);
      chk("reply id", mq[0], 8'h14);
      mute = 1'b1;
      send_req(8'h14);
      for (int i = 0; i < 6000 && mq.size() < 6; i++)
         @(posedge ref_clk);
      chk("cached", mq.size(), 6);
      send_req(8'h15);
      repeat (6000) @(posedge ref_clk);
      ahb(1'b0, A_STAT, 0);
      chk("timeouts", r, 32'h1);
      chk("no reply", mq.size(), 0);
      send_req(8'hFA);
      repeat (50) @(posedge ref_clk);
      ahb(1'b0, A_STAT, 0);
      chk("drops", r, 32'h10001);
      final_report();
   end
endmodule
`default_nettype wire
